// ===== bench/eirq_pins.sv
// model of the external pins feeding the interrupt lines
module eirq_pins (
  input  wire logic       clk,
  input  wire logic [8:0] want,
  output logic      [8:0] irq_lines
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins move just after a clock edge, like a board-level source
  always_ff @(posedge clk) irq_lines <= want;
endmodule

// ===== bench/test_eirq_regs.sv
// self-checking bench for the external interrupt register block
module test_eirq_regs;
  import eirq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [5:0]  adr = '0;
  logic [31:0] dat = '0;
  logic [31:0] rdat;
  logic        ack;
  logic [3:0]  sel = 4'hf;
  logic        hung = 1'b0;
  logic        irq;
  logic        g;
  logic [95:0] r;
  logic [8:0]  pins, line_req, t, e, l, f, po, pn, s, c, fl;
  logic [8:0]  want = '0;
  logic [8:0]  m = '0;
  logic [5:0]  rr [7] = '{OFS_MASK_STATE, OFS_EVENT_FLAGS, OFS_TRIG_TYPE, OFS_EDGE_POL,
                          OFS_LEVEL_POL, OFS_FILTER_SEL, 6'h24};
  int          num_errors = 0;
  int          checks = 0;
  always #20 clk = ~clk;
  eirq_regs DUT (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_lines(pins), .line_req(line_req), .irq(irq));
  eirq_pins PINS (.clk(clk), .want(want), .irq_lines(pins));
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(logic w, logic [5:0] a, logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    q = '0;
    if (hung) return;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // ack and read data are taken as they stood at the rising edge
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1) begin
      num_errors++;
      hung = 1'b1;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(logic [5:0] a, logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(string nm, logic [5:0] a, logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, '0, q);
    chk(nm, q, exp);
  endtask
  // events expected after the pins go from o to n
  function automatic logic [8:0] hits(logic [8:0] o, n, ty, ep, lp);
    return (ty & ~((o ^ lp) & (n ^ lp))) | (~ty & (o ^ n) & ~(n ^ ep));
  endfunction
  initial begin
    void'($urandom(32'h7c968f29));
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    foreach (rr[k]) rdc("reset", rr[k], 32'h0);
    $display("reset test done");
    // lane 1 alone carries only the non-maskable bit
    sel <= 4'h2;
    wr(OFS_MASK_SET, 32'h1ff);
    rdc("lane_set", OFS_MASK_STATE, 32'h100);
    wr(OFS_MASK_CLEAR, 32'h1ff);
    sel <= 4'hf;
    rdc("lane_clear", OFS_MASK_STATE, 32'h0);
    $display("lane test done");
    for (int i = 0; i < 24; i++) begin
      if (hung) break;
      r = {$urandom(), $urandom(), $urandom()};
      {t, e, l, f, po, pn, s, c} = r[71:0];
      g = (i % 4 == 0);
      if (g) begin
        t = '1;
        l = '1;
        po = '0;
        pn = '1;
      end
      want <= po;
      wr(OFS_LINE_EN, 32'h1ff);
      wr(OFS_TRIG_TYPE, {r[95:73], t});
      wr(OFS_EDGE_POL, {23'h0, e});
      wr(OFS_LEVEL_POL, {23'h0, l});
      wr(OFS_FILTER_SEL, {23'h0, f});
      rdc("trig", OFS_TRIG_TYPE, {23'h0, t});
      rdc("edge", OFS_EDGE_POL, {23'h0, e});
      rdc("level", OFS_LEVEL_POL, {23'h0, l});
      rdc("filter", OFS_FILTER_SEL, {23'h0, f});
      wr(OFS_MASK_SET, {r[95:73], s});
      wr(OFS_MASK_CLEAR, {23'h0, c});
      m = (m | s) & ~c;
      rdc("mask", OFS_MASK_STATE, {23'h0, m});
      repeat (8) @(posedge clk);
      wr(OFS_EVENT_CLEAR, 32'h1ff);
      want <= pn;
      if (g) begin
        @(posedge clk);
        want <= po;
      end
      repeat (8) @(posedge clk);
      fl = g ? ~f : hits(po, pn, t, e, l);
      rdc("flags", OFS_EVENT_FLAGS, {23'h0, fl});
      @(negedge clk);
      chk("line_req", {23'h0, line_req}, {23'h0, fl & m});
      chk("irq", {31'h0, irq}, {31'h0, |(fl & m)});
      wr(OFS_EVENT_CLEAR, {r[95:73], c});
      fl = (fl & ~c) | (t & ~((g ? po : pn) ^ l));
      rdc("clear", OFS_EVENT_FLAGS, {23'h0, fl});
      wr(OFS_LINE_DIS, {23'h0, s});
      rdc("disabled", OFS_EVENT_FLAGS, {23'h0, fl & ~s});
      rdc("line_state", OFS_LINE_STATE, {23'h0, ~s});
      $display("test %0d done", i);
    end
    // reset again after the random tests: every register in rr (not line_state) must come back cleared
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    foreach (rr[k]) rdc("rerun", rr[k], 32'h0);
    @(negedge clk);
    chk("irq_reset", {31'h0, irq}, 32'h0);
    $display("reset again test done");
    print_verdict();
  end
endmodule

// ===== common/eirq_pkg.sv
// constants and types of the external interrupt register block
// Operation
// - writing one to a mask_set bit sets that mask bit; zeros change nothing
// - writing one to a mask_clear bit clears that mask bit; zeros change nothing
// - mask_state reads one bit per line, lines 0-7 at bits 0-7, non-maskable at 8
// - an event flag reads one after an event and stays until software clears it
// - writing one to an event_flag_clear bit clears that flag; zeros change nothing
// - trigger type bit zero selects edge detection, one selects level detection
// - edge polarity bit zero detects falling edges, one detects rising edges
// - level polarity bit zero triggers on low level, one on high level
// - the non-maskable line behaves like the others, on its own bit 8
// - filter select one routes the line through a three-sample majority vote
// - while a line is disabled its event flag reads zero
package eirq_pkg;
  localparam int          EIRQ_LINES      = 9;
  localparam logic [5:0]  OFS_MASK_SET    = 6'h00;
  localparam logic [5:0]  OFS_MASK_CLEAR  = 6'h04;
  localparam logic [5:0]  OFS_MASK_STATE  = 6'h08;
  localparam logic [5:0]  OFS_EVENT_FLAGS = 6'h0c;
  localparam logic [5:0]  OFS_EVENT_CLEAR = 6'h10;
  localparam logic [5:0]  OFS_TRIG_TYPE   = 6'h14;
  localparam logic [5:0]  OFS_EDGE_POL    = 6'h18;
  localparam logic [5:0]  OFS_LEVEL_POL   = 6'h1c;
  localparam logic [5:0]  OFS_FILTER_SEL  = 6'h20;
  localparam logic [5:0]  OFS_LINE_EN     = 6'h30;
  localparam logic [5:0]  OFS_LINE_DIS    = 6'h34;
  localparam logic [5:0]  OFS_LINE_STATE  = 6'h38;
  localparam logic [8:0]  LINES_RESET     = 9'h000;

  typedef struct packed {
    logic [8:0]  sync1;
    logic [8:0]  sync2;
    logic [8:0]  hist1;
    logic [8:0]  hist2;
    logic [8:0]  cond_prev;
    logic [8:0]  mask;
    logic [8:0]  flags;
    logic [8:0]  trig_type;
    logic [8:0]  edge_pol;
    logic [8:0]  level_pol;
    logic [8:0]  filter_sel;
    logic [8:0]  line_en;
    logic        ack;
    logic [31:0] rdata;
  } eirq_state_t;
endpackage

// ===== core/eirq_regs.sv
// external interrupt register block with wishbone slave
module eirq_regs
  import eirq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [8:0]  irq_lines,
  output logic      [8:0]  line_req,
  output logic             irq
);
  eirq_state_t s_r;
  eirq_state_t s_nxt;

  logic        req;
  logic        wr;
  logic [8:0]  wbits;
  logic [8:0]  cond;
  logic [8:0]  filt;
  logic [8:0]  evt;
  logic        dis_wr;

  // majority of three samples
  function automatic logic [8:0] vote3(input logic [8:0] a, input logic [8:0] b,
                                       input logic [8:0] c);
    vote3 = (a & b) | (a & c) | (b & c);
  endfunction

  assign req   = wb_cyc_i && wb_stb_i && !s_r.ack;
  assign wr    = req && wb_we_i;
  assign wbits = {wb_sel_i[1] & wb_dat_i[8], wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
  assign dis_wr = wr && (wb_adr_i == OFS_LINE_DIS);

  always_comb begin
    s_nxt = s_r;
    // per line trigger condition, polarity chosen by mode
    for (int i = 0; i < EIRQ_LINES; i++) begin
      if (s_r.trig_type[i]) begin
        cond[i] = s_r.level_pol[i] ? s_r.sync2[i] : !s_r.sync2[i];
      end else begin
        cond[i] = s_r.edge_pol[i] ? s_r.sync2[i] : !s_r.sync2[i];
      end
    end
    filt = vote3(cond, s_r.hist1, s_r.hist2);
    for (int i = 0; i < EIRQ_LINES; i++) begin
      if (!s_r.filter_sel[i]) begin
        filt[i] = cond[i];
      end
    end
    // edge lines fire on inactive-to-active of the (filtered) condition
    evt = s_r.line_en & ((s_r.trig_type & filt) | (~s_r.trig_type & filt & ~s_r.cond_prev));
    s_nxt.sync1     = irq_lines;
    s_nxt.sync2     = s_r.sync1;
    s_nxt.hist1     = cond;
    s_nxt.hist2     = s_r.hist1;
    s_nxt.cond_prev = filt;
    s_nxt.ack       = req;
    s_nxt.rdata     = 32'h0000_0000;
    if (wr && wb_adr_i == OFS_MASK_SET) begin
      s_nxt.mask = s_r.mask | wbits;
    end else if (wr && wb_adr_i == OFS_MASK_CLEAR) begin
      s_nxt.mask = s_r.mask & ~wbits;
    end
    if (wr && wb_adr_i == OFS_EVENT_CLEAR) begin
      s_nxt.flags = s_r.flags & ~wbits;
    end
    if (wr && wb_adr_i == OFS_TRIG_TYPE) begin
      s_nxt.trig_type = wbits;
    end else if (wr && wb_adr_i == OFS_EDGE_POL) begin
      s_nxt.edge_pol = wbits;
    end else if (wr && wb_adr_i == OFS_LEVEL_POL) begin
      s_nxt.level_pol = wbits;
    end else if (wr && wb_adr_i == OFS_FILTER_SEL) begin
      s_nxt.filter_sel = wbits;
    end else if (wr && wb_adr_i == OFS_LINE_EN) begin
      s_nxt.line_en = s_r.line_en | wbits;
    end else if (wr && wb_adr_i == OFS_LINE_DIS) begin
      s_nxt.line_en = s_r.line_en & ~wbits;
    end
    // set wins over clear; disabled lines hold no flag
    s_nxt.flags = (s_nxt.flags | evt) & s_nxt.line_en;
    if (req && !wb_we_i) begin
      if (wb_adr_i == OFS_MASK_STATE) begin
        s_nxt.rdata = {23'h000000, s_r.mask};
      end else if (wb_adr_i == OFS_EVENT_FLAGS) begin
        s_nxt.rdata = {23'h000000, s_r.flags};
      end else if (wb_adr_i == OFS_TRIG_TYPE) begin
        s_nxt.rdata = {23'h000000, s_r.trig_type};
      end else if (wb_adr_i == OFS_EDGE_POL) begin
        s_nxt.rdata = {23'h000000, s_r.edge_pol};
      end else if (wb_adr_i == OFS_LEVEL_POL) begin
        s_nxt.rdata = {23'h000000, s_r.level_pol};
      end else if (wb_adr_i == OFS_FILTER_SEL) begin
        s_nxt.rdata = {23'h000000, s_r.filter_sel};
      end else if (wb_adr_i == OFS_LINE_STATE) begin
        s_nxt.rdata = {23'h000000, s_r.line_en};
      end else begin
        s_nxt.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.rdata;
  assign line_req = s_r.flags & s_r.mask;
  assign irq      = |line_req;

  property p_mask_set;
    @(posedge clk) disable iff (!arst_n)
      (wr && wb_adr_i == OFS_MASK_SET && wb_sel_i[0] && wb_dat_i[0]) |=> s_r.mask[0];
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask set failed");

  property p_mask_clr;
    @(posedge clk) disable iff (!arst_n)
      (wr && wb_adr_i == OFS_MASK_CLEAR && wb_sel_i[1] && wb_dat_i[8]) |=> !s_r.mask[8];
  endproperty
  a_mask_clr: assert property (p_mask_clr) else $error("mask clear failed");

  property p_mask_read;
    @(posedge clk) disable iff (!arst_n)
      (req && !wb_we_i && wb_adr_i == OFS_MASK_STATE) |=> wb_dat_o == {23'h0, $past(s_r.mask)};
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

  property p_flag_hold;
    @(posedge clk) disable iff (!arst_n)
      (s_r.flags[1] && s_r.line_en[1] && !(wr && wb_adr_i == OFS_EVENT_CLEAR)
       && !(wr && wb_adr_i == OFS_LINE_DIS)) |=> s_r.flags[1];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

  property p_flag_clr;
    @(posedge clk) disable iff (!arst_n)
      (wr && wb_adr_i == OFS_EVENT_CLEAR && wb_sel_i[0] && wb_dat_i[2] && !evt[2])
      |=> !s_r.flags[2];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag clear failed");

  property p_level;
    @(posedge clk) disable iff (!arst_n)
      (s_r.line_en[3] && s_r.trig_type[3] && !s_r.filter_sel[3]
       && s_r.sync2[3] == s_r.level_pol[3] && !dis_wr) |=> s_r.flags[3];
  endproperty
  a_level: assert property (p_level) else $error("level event missed");

  property p_rise;
    @(posedge clk) disable iff (!arst_n)
      (s_r.line_en[4] && !s_r.trig_type[4] && s_r.edge_pol[4] && !s_r.filter_sel[4]
       && s_r.sync2[4] && !s_r.cond_prev[4] && !dis_wr) |=> s_r.flags[4];
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");

  property p_disabled;
    @(posedge clk) disable iff (!arst_n)
      !s_r.line_en[5] |-> !s_r.flags[5];
  endproperty
  a_disabled: assert property (p_disabled) else $error("flag on disabled line");

  // request toward the cpu follows a fresh unmasked event
  property p_req;
    @(posedge clk) disable iff (!arst_n)
      (evt[1] && s_r.mask[1] && !dis_wr && !(wr && wb_adr_i == OFS_MASK_CLEAR)) |=> irq;
  endproperty
  a_req: assert property (p_req) else $error("request missed");

  property p_mask_keep;
    @(posedge clk) disable iff (!arst_n)
      (wr && wb_adr_i == OFS_MASK_SET && wb_sel_i[0] && !wb_dat_i[1])
      |=> s_r.mask[1] == $past(s_r.mask[1]);
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("mask set moved a zero bit");

  property p_unmask_keep;
    @(posedge clk) disable iff (!arst_n)
      (wr && wb_adr_i == OFS_MASK_CLEAR && wb_sel_i[0] && !wb_dat_i[3])
      |=> s_r.mask[3] == $past(s_r.mask[3]);
  endproperty
  a_unmask_keep: assert property (p_unmask_keep) else $error("mask clear moved a bit");

  property p_nmi_mask;
    @(posedge clk) disable iff (!arst_n)
      (wr && wb_adr_i == OFS_MASK_SET && wb_sel_i[1] && wb_dat_i[8])
      |=> s_r.mask[8];
  endproperty
  a_nmi_mask: assert property (p_nmi_mask) else $error("nmi mask set failed");

  property p_flag_read;
    @(posedge clk) disable iff (!arst_n)
      (req && !wb_we_i && wb_adr_i == OFS_EVENT_FLAGS)
      |=> wb_dat_o == {23'h000000, $past(s_r.flags)};
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag read wrong");

  property p_clear_keep;
    @(posedge clk) disable iff (!arst_n)
      (wr && wb_adr_i == OFS_EVENT_CLEAR && wb_sel_i[0] && !wb_dat_i[6] && s_r.flags[6])
      |=> s_r.flags[6];
  endproperty
  a_clear_keep: assert property (p_clear_keep) else $error("flag clear hit a zero bit");

  property p_fall;
    @(posedge clk) disable iff (!arst_n)
      (s_r.line_en[6] && !s_r.trig_type[6] && !s_r.edge_pol[6] && !s_r.filter_sel[6]
       && !s_r.sync2[6] && !s_r.cond_prev[6] && !dis_wr)
      |=> s_r.flags[6];
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");

  property p_low;
    @(posedge clk) disable iff (!arst_n)
      (s_r.line_en[2] && s_r.trig_type[2] && !s_r.level_pol[2] && !s_r.filter_sel[2]
       && !s_r.sync2[2] && !dis_wr)
      |=> s_r.flags[2];
  endproperty
  a_low: assert property (p_low) else $error("low level missed");

  property p_edge_once;
    @(posedge clk) disable iff (!arst_n)
      (!s_r.trig_type[7] && !s_r.filter_sel[7] && !s_r.flags[7] && s_r.cond_prev[7])
      |=> !s_r.flags[7];
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge line fired on level");

  property p_filt_block;
    @(posedge clk) disable iff (!arst_n)
      (s_r.filter_sel[0] && !s_r.flags[0] && !s_r.hist1[0] && !s_r.hist2[0])
      |=> !s_r.flags[0];
  endproperty
  a_filt_block: assert property (p_filt_block) else $error("filter passed a spike");

  property p_filt_pass;
    @(posedge clk) disable iff (!arst_n)
      (s_r.line_en[0] && s_r.trig_type[0] && s_r.filter_sel[0]
       && s_r.hist1[0] && s_r.hist2[0] && !dis_wr)
      |=> s_r.flags[0];
  endproperty
  a_filt_pass: assert property (p_filt_pass) else $error("filter lost a level");

  property p_nmi_level;
    @(posedge clk) disable iff (!arst_n)
      (s_r.line_en[8] && s_r.trig_type[8] && !s_r.filter_sel[8]
       && s_r.sync2[8] == s_r.level_pol[8] && !dis_wr)
      |=> s_r.flags[8];
  endproperty
  a_nmi_level: assert property (p_nmi_level) else $error("nmi level missed");

  // bus handshake, read data padding and register write checks
  property p_ack_pulse;
    @(posedge clk) disable iff (!arst_n)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_ack_take;
    @(posedge clk) disable iff (!arst_n)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_take: assert property (p_ack_take) else $error("request not acked");

  property p_rdata_pad;
    @(posedge clk) disable iff (!arst_n)
      wb_ack_o |-> wb_dat_o[31:9] == 23'h000000;
  endproperty
  a_rdata_pad: assert property (p_rdata_pad) else $error("upper read bits set");

  property p_trig_write;
    @(posedge clk) disable iff (!arst_n)
      (wr && wb_adr_i == OFS_TRIG_TYPE && wb_sel_i[0])
      |=> s_r.trig_type[7:0] == $past(wb_dat_i[7:0]);
  endproperty
  a_trig_write: assert property (p_trig_write) else $error("trigger type write lost");

  property p_pol_write;
    @(posedge clk) disable iff (!arst_n)
      (wr && wb_adr_i == OFS_EDGE_POL && wb_sel_i[1])
      |=> s_r.edge_pol[8] == $past(wb_dat_i[8]);
  endproperty
  a_pol_write: assert property (p_pol_write) else $error("edge polarity write lost");

  property p_filt_write;
    @(posedge clk) disable iff (!arst_n)
      (wr && wb_adr_i == OFS_FILTER_SEL && wb_sel_i[0])
      |=> s_r.filter_sel[7:0] == $past(wb_dat_i[7:0]);
  endproperty
  a_filt_write: assert property (p_filt_write) else $error("filter write lost");

  c_irq: cover property (@(posedge clk) disable iff (!arst_n) $rose(irq));
  c_nmi: cover property (@(posedge clk) disable iff (!arst_n) $rose(s_r.flags[8]));
  c_filt: cover property (@(posedge clk) disable iff (!arst_n) |(evt & s_r.filter_sel));
  c_lane: cover property (@(posedge clk) disable iff (!arst_n) wr && !wb_sel_i[1]);
  c_dis: cover property (@(posedge clk) disable iff (!arst_n) dis_wr && |s_r.flags);
endmodule
